// ==== pkg/ssr_pkg.sv ====
// constants for the safety state reporter
package ssr_pkg;
   // register byte offsets on the wishbone bus
   localparam logic [4:0] OFS_STATE = 5'h00;
   localparam logic [4:0] OFS_SUB = 5'h04;
   localparam logic [4:0] OFS_ERRC = 5'h08;
   localparam logic [4:0] OFS_ERRD = 5'h0c;
   localparam logic [4:0] OFS_CTRL = 5'h10;
   localparam logic [4:0] OFS_CMD = 5'h14;
   localparam logic [4:0] OFS_DLY = 5'h18;
   // field positions
   localparam int CTRL_EXT_BIT = 0;
   localparam int CTRL_ACK_BIT = 1;
   localparam int CMD_LSB = 0;
   localparam int PBITS_LSB = 8;
   // reset values
   localparam logic [23:0] DLY_RST = 24'h000000;
   localparam logic CTRL_EXT_RST = 1'b0;
   // operating state codes
   localparam logic [3:0] ST_RUN = 4'h0;
   localparam logic [3:0] ST_INIT = 4'h1;
   localparam logic [3:0] ST_BASIC = 4'h2;
   localparam logic [3:0] ST_PARAM = 4'h3;
   localparam logic [3:0] ST_RELOAD = 4'h4;
   localparam logic [3:0] ST_MODCHG = 4'h5;
   localparam logic [3:0] ST_ERROR = 4'h6;
   localparam logic [3:0] ST_SAFEFN = 4'h7;
   localparam logic [3:0] ST_ENCFAIL = 4'h8;
   // last sub-status step of init and basic
   localparam logic [7:0] INIT_LAST = 8'h08;
   localparam logic [7:0] BASIC_LAST = 8'h0d;
   // software commands
   localparam logic [2:0] CMD_PARAM = 3'h1;
   localparam logic [2:0] CMD_RELOAD = 3'h2;
   localparam logic [2:0] CMD_MODCHG = 3'h3;
   localparam logic [2:0] CMD_RESUME = 3'h4;
   // codes for errors found outside the internal checks
   localparam logic [7:0] ERR_FIELDBUS = 8'h31;
   localparam logic [7:0] ERR_PER_SHORT = 8'h32;
   localparam logic [7:0] ERR_PER_CROSS = 8'h33;
   // encoder standstill time
   localparam int CLK_HZ = 25000000;
   localparam longint ENC_IDLE_HOURS = 12;
   localparam longint ENC_IDLE_CYC = ENC_IDLE_HOURS * 64'd3600 * CLK_HZ;
endpackage

// ==== logic/ssr_sync2.sv ====
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/100ps
module ssr_sync2 #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // asynchronous levels in, synchronised levels out
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   // first stage, read only by the second stage
   logic [W-1:0] meta;

   // two stages to let metastability settle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         meta <= '0;
         q_o <= '0;
      end
      else
      begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule // ssr_sync2

// ==== logic/ssr_top.sv ====
// safety state reporter: operating state, sub-status, error capture, torque off
//
// Chosen here: the Wishbone interface to the registers and the address map.
`timescale 1ns/100ps
module ssr_top #(
   parameter longint ENC_IDLE = ssr_pkg::ENC_IDLE_CYC
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // classic wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // sequencer, internal error and fieldbus fault reports, same clock
   input wire logic step_done_i,
   input wire logic int_err_i,
   input wire logic int_err_crit_i,
   input wire logic [7:0] int_err_code_i,
   input wire logic [15:0] int_err_detail_i,
   input wire logic fb_fault_i,
   // pins from outside the clock domain
   input wire logic [1:0] lim_ax_i,
   input wire logic per_short_i,
   input wire logic per_cross_i,
   input wire logic enc_move_i,
   // torque off and red indicator
   output logic sto_o,
   output logic led_err_o
);
   // one-hot sequence states
   typedef enum logic [8:0] {
      SSR_RUN = 9'h001,
      SSR_INIT = 9'h002,
      SSR_BASIC = 9'h004,
      SSR_PARAM = 9'h008,
      SSR_RELOAD = 9'h010,
      SSR_MODCHG = 9'h020,
      SSR_ERROR = 9'h040,
      SSR_SAFEFN = 9'h080,
      SSR_ENCFAIL = 9'h100
   } ssr_state_e;

   ssr_state_e st; // current state
   ssr_state_e next_st; // state after this edge
   logic [7:0] sub; // sub-status or bit field
   logic [7:0] next_sub;
   logic [7:0] err_code; // latched error code
   logic [15:0] err_det; // latched error detail
   logic ext_sw; // extended software enabled
   logic [23:0] dly; // reaction delay in cycles
   logic [23:0] dly_cnt; // reaction delay countdown
   logic dly_pend; // torque still held during delay
   logic [39:0] enc_cnt; // encoder standstill cycles
   logic enc_prev; // last encoder level
   logic [3:0] pins_s; // synchronised pin levels

   // pin synchronisers
   ssr_sync2 #(.W(4)) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i({enc_move_i, per_cross_i, per_short_i, lim_ax_i[1]}),
      .q_o(pins_s)
   );

   // lim bit 0 is synchronised on its own instance
   logic lim0_s;
   ssr_sync2 #(.W(1)) u_sync_l0 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(lim_ax_i[0]),
      .q_o(lim0_s)
   );

   wire [1:0] lim_s = {pins_s[0], lim0_s};
   wire short_s = pins_s[1];
   wire cross_s = pins_s[2];
   wire enc_s = pins_s[3];

   // bus decode
   wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire bus_wr = bus_req & wb_we_i;
   wire wr_ctrl = bus_wr & (wb_adr_i == ssr_pkg::OFS_CTRL) & wb_sel_i[0];
   wire wr_cmd = bus_wr & (wb_adr_i == ssr_pkg::OFS_CMD) & wb_sel_i[0];
   wire wr_dly = bus_wr & (wb_adr_i == ssr_pkg::OFS_DLY);
   wire [2:0] cmd = wb_dat_i[ssr_pkg::CMD_LSB +: 3];
   wire [3:0] pbits = wb_dat_i[ssr_pkg::PBITS_LSB +: 4];
   // acknowledge only counts in the encoder failure state
   wire enc_ack = wr_ctrl & wb_dat_i[ssr_pkg::CTRL_ACK_BIT];

   // error sources; periphery faults come from the cable diagnostics
   wire per_err = short_s | cross_s;
   wire err_any = int_err_i | fb_fault_i | per_err;
   // external faults are treated as system-critical: no delay
   wire err_crit = ~int_err_i | int_err_crit_i;
   wire [7:0] err_sel_code = int_err_i ? int_err_code_i :
                             fb_fault_i ? ssr_pkg::ERR_FIELDBUS :
                             short_s ? ssr_pkg::ERR_PER_SHORT :
                             ssr_pkg::ERR_PER_CROSS;
   wire [15:0] err_sel_det = int_err_i ? int_err_detail_i : 16'h0000;
   wire err_new = err_any & (st != SSR_ERROR);
   wire enc_edge = enc_s ^ enc_prev;
   wire enc_idle = (enc_cnt >= ENC_IDLE[39:0]);

   // state code shown to the host
   logic [3:0] code;
   always_comb
   begin
      unique case (st)
         SSR_RUN: code = ssr_pkg::ST_RUN;
         SSR_INIT: code = ssr_pkg::ST_INIT;
         SSR_BASIC: code = ssr_pkg::ST_BASIC;
         SSR_PARAM: code = ssr_pkg::ST_PARAM;
         SSR_RELOAD: code = ssr_pkg::ST_RELOAD;
         SSR_MODCHG: code = ssr_pkg::ST_MODCHG;
         SSR_ERROR: code = ssr_pkg::ST_ERROR;
         SSR_SAFEFN: code = ssr_pkg::ST_SAFEFN;
         SSR_ENCFAIL: code = ssr_pkg::ST_ENCFAIL;
         default: code = ssr_pkg::ST_ERROR;
      endcase
   end

   // sequencing: error beats everything, commands only from stable states
   always_comb
   begin
      next_st = st;
      next_sub = sub;
      if (err_new)
      begin
         next_st = SSR_ERROR;
         next_sub = 8'h00;
      end
      else
      begin
         unique case (st)
            SSR_INIT:
            begin
               // steps 0..8, then basic start-up
               if (step_done_i && sub == ssr_pkg::INIT_LAST)
               begin
                  next_st = SSR_BASIC;
                  next_sub = 8'h00;
               end
               else if (step_done_i)
                  next_sub = sub + 8'h01;
            end
            SSR_BASIC:
            begin
               // steps 0..8, waits 9..12, parameter check 13
               if (step_done_i && sub == ssr_pkg::BASIC_LAST)
               begin
                  next_st = SSR_RUN;
                  next_sub = 8'h00;
               end
               else if (step_done_i)
                  next_sub = sub + 8'h01;
            end
            SSR_RUN:
            begin
               if (|lim_s)
               begin
                  next_st = SSR_SAFEFN;
                  next_sub = {6'h00, lim_s};
               end
               else if (ext_sw && enc_idle)
                  next_st = SSR_ENCFAIL;
               else if (wr_cmd && cmd == ssr_pkg::CMD_PARAM)
               begin
                  next_st = SSR_PARAM;
                  next_sub = {4'h0, pbits};
               end
               else if (wr_cmd && cmd == ssr_pkg::CMD_RELOAD)
                  next_st = SSR_RELOAD;
               else if (wr_cmd && cmd == ssr_pkg::CMD_MODCHG)
                  next_st = SSR_MODCHG;
            end
            SSR_PARAM, SSR_RELOAD, SSR_MODCHG:
            begin
               // a new param command updates the bit field in place
               if (wr_cmd && cmd == ssr_pkg::CMD_PARAM && st == SSR_PARAM)
                  next_sub = {4'h0, pbits};
               else if (wr_cmd && cmd == ssr_pkg::CMD_RESUME)
               begin
                  next_st = SSR_INIT;
                  next_sub = 8'h00;
               end
            end
            SSR_SAFEFN:
            begin
               // axis bits follow the limit inputs until both clear
               next_sub = {6'h00, lim_s};
               if (lim_s == 2'b00)
                  next_st = SSR_RUN;
            end
            SSR_ENCFAIL:
            begin
               if (enc_ack)
                  next_st = SSR_RUN;
            end
            SSR_ERROR:
            begin
               // fail-safe: only a reset leaves the error state
               next_st = SSR_ERROR;
            end
            default:
            begin
               next_st = SSR_ERROR;
               next_sub = 8'h00;
            end
         endcase
      end
   end

   // state and sub-status registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st <= SSR_INIT;
         sub <= 8'h00;
      end
      else
      begin
         st <= next_st;
         sub <= next_sub;
      end
   end

   // first error is latched; later ones do not overwrite it
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         err_code <= 8'h00;
         err_det <= 16'h0000;
      end
      else if (err_new)
      begin
         err_code <= err_sel_code;
         err_det <= err_sel_det;
      end
   end

   // reaction delay: only for non-critical errors hitting a running drive
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         dly_cnt <= 24'h000000;
         dly_pend <= 1'b0;
      end
      else if (err_new)
      begin
         dly_cnt <= dly;
         dly_pend <= (st == SSR_RUN) & ~err_crit & (dly != 24'h000000);
      end
      else if (dly_pend)
      begin
         dly_cnt <= dly_cnt - 24'h000001;
         dly_pend <= (dly_cnt != 24'h000001);
      end
   end

   // pending flag as it will stand after this edge
   logic dly_pend_next;
   assign dly_pend_next = err_new ? ((st == SSR_RUN) & ~err_crit & (dly != 24'h000000)) :
                          (dly_pend & (dly_cnt != 24'h000001));

   // torque only while running or during a pending reaction delay
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sto_o <= 1'b1;
         led_err_o <= 1'b0;
      end
      else
      begin
         sto_o <= ~(next_st == SSR_RUN) & ~(next_st == SSR_ERROR & dly_pend_next);
         led_err_o <= (next_st == SSR_ERROR);
      end
   end

   // encoder standstill counter; saturates so it cannot wrap
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         enc_cnt <= 40'h0000000000;
         enc_prev <= 1'b0;
      end
      else
      begin
         enc_prev <= enc_s;
         if (enc_edge || st != SSR_RUN || !ext_sw)
            enc_cnt <= 40'h0000000000;
         else if (!enc_idle)
            enc_cnt <= enc_cnt + 40'h0000000001;
      end
   end

   // software registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ext_sw <= ssr_pkg::CTRL_EXT_RST;
         dly <= ssr_pkg::DLY_RST;
      end
      else
      begin
         if (wr_ctrl)
            ext_sw <= wb_dat_i[ssr_pkg::CTRL_EXT_BIT];
         if (wr_dly)
            dly <= wb_dat_i[23:0];
      end
   end

   // read mux; unmapped offsets read zero
   logic [31:0] rd;
   always_comb
   begin
      unique case (wb_adr_i)
         ssr_pkg::OFS_STATE: rd = {28'h0000000, code};
         ssr_pkg::OFS_SUB: rd = {24'h000000, sub};
         ssr_pkg::OFS_ERRC: rd = {24'h000000, err_code};
         ssr_pkg::OFS_ERRD: rd = {16'h0000, err_det};
         ssr_pkg::OFS_CTRL: rd = {31'h00000000, ext_sw};
         ssr_pkg::OFS_DLY: rd = {8'h00, dly};
         default: rd = 32'h00000000;
      endcase
   end

   // one wait state: ack one cycle after the request, dropped next cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req ? rd : 32'h00000000;
      end
   end

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_err_forces_error: assert property (err_any |=> st == SSR_ERROR)
      else $error("error did not enter error state");
   a_ext_err_code: assert property (!int_err_i && fb_fault_i && err_new |=> err_code == ssr_pkg::ERR_FIELDBUS)
      else $error("fieldbus fault code wrong");
   a_led_tracks: assert property (led_err_o == (st == SSR_ERROR))
      else $error("red indicator wrong");
   a_crit_sto: assert property (err_new && err_crit |=> sto_o)
      else $error("critical error left torque on");
   a_delay_holds: assert property (err_new && st == SSR_RUN && !err_crit && dly == 24'h000003
                                   |=> !sto_o ##1 !sto_o ##1 !sto_o ##1 sto_o)
      else $error("reaction delay length wrong");
   a_init_step: assert property (st == SSR_INIT && step_done_i && !err_any && sub < ssr_pkg::INIT_LAST
                                 |=> sub == $past(sub) + 8'h01)
      else $error("init step did not advance");
   a_basic_end: assert property (st == SSR_BASIC && sub == ssr_pkg::BASIC_LAST && step_done_i && !err_any
                                 |=> st == SSR_RUN)
      else $error("basic did not finish");
   a_enc_ack: assert property (st == SSR_ENCFAIL && enc_ack && !err_any |=> st == SSR_RUN)
      else $error("encoder ack ignored");
   a_safefn_bits: assert property (st == SSR_RUN && |lim_s && !err_any |=> st == SSR_SAFEFN && sub[1:0] == $past(lim_s))
      else $error("axis bits wrong");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");

   c_reach_run: cover property (st == SSR_BASIC ##1 st == SSR_RUN);
   c_error: cover property (st == SSR_RUN ##1 st == SSR_ERROR);
   c_encfail: cover property (st == SSR_ENCFAIL ##1 st == SSR_RUN);
   c_param: cover property (st == SSR_PARAM);
endmodule // ssr_top

// ==== bench/ssr_env.sv ====
// partner model: sequencer step pulses and encoder motion
`timescale 1ns/100ps
module ssr_env (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // encoder motion request from the bench
   input wire logic enc_on_i,
   // step pulses and encoder level
   output logic step_done_o,
   output logic enc_move_o
);
   logic [1:0] div; // toggle divider for the encoder line
   initial step_done_o = 1'b0;
   // encoder toggles every fourth cycle while moving, stands still otherwise
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         div <= 2'h0;
         enc_move_o <= 1'b0;
      end
      else
      begin
         div <= div + 2'h1;
         if (enc_on_i && div == 2'h3)
            enc_move_o <= ~enc_move_o;
      end
   end
   // n back-to-back steps; a held level counts once per edge
   task automatic steps(input int n);
      step_done_o <= 1'b1;
      repeat (n) @(posedge clk_i);
      step_done_o <= 1'b0;
   endtask
endmodule // ssr_env

// ==== bench/tb.sv ====
// self-checking bench for the safety state reporter
`timescale 1ns/100ps
module tb;
   logic clk_i, rst_i; // clock and reset
   logic cyc, stb, we, ack; // bus handshake
   logic [4:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, dat_o;
   logic sto, led, step, enc, enc_on; // pins
   logic err, crit;
   logic [7:0] ecode;
   logic [15:0] edet;
   logic [2:0] ext_f; // fieldbus, short, cross
   logic [1:0] lim;
   logic [7:0] ex_codes [3]; // codes of outside faults
   int mismatches, total_checks, i, k;
   // short standstill limit keeps the run brief
   ssr_top #(.ENC_IDLE(20)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .step_done_i(step), .int_err_i(err), .int_err_crit_i(crit),
      .int_err_code_i(ecode), .int_err_detail_i(edet), .fb_fault_i(ext_f[0]), .lim_ax_i(lim),
      .per_short_i(ext_f[1]), .per_cross_i(ext_f[2]), .enc_move_i(enc), .sto_o(sto), .led_err_o(led));
   ssr_env env (.clk_i(clk_i), .rst_i(rst_i), .enc_on_i(enc_on), .step_done_o(step), .enc_move_o(enc));
   // 25 MHz clock
   initial
   begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   // verdict and end of run
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // compare seen against expected
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one classic cycle; ack is taken at the edge, a lost ack ends the run
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (ack !== 1'b1)
      begin
         mismatches++;
         complete_run();
      end
      @(posedge clk_i);
   endtask
   // read and compare
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask
   // reset held for 16 cycles
   task automatic do_reset;
      rst_i <= 1'b1;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
   endtask
   // reset and run all init and basic steps through to run
   task automatic boot;
      do_reset();
      env.steps(23);
   endtask
   // main sequence
   initial
   begin
      rst_i = 1'b1;
      {cyc, stb, we, err, crit, enc_on} = 6'h00;
      adr = 5'h00;
      sel = 4'hf;
      wdat = 32'h0;
      ecode = 8'h00;
      edet = 16'h0000;
      ext_f = 3'h0;
      lim = 2'h0;
      ex_codes[0] = ssr_pkg::ERR_FIELDBUS;
      ex_codes[1] = ssr_pkg::ERR_PER_SHORT;
      ex_codes[2] = ssr_pkg::ERR_PER_CROSS;
      mismatches = 0;
      total_checks = 0;
      do_reset();
      // reset values, unmapped place
      rd(ssr_pkg::OFS_STATE, 32'(ssr_pkg::ST_INIT));
      rd(ssr_pkg::OFS_SUB, 32'h0);
      bus(1'b1, 5'h1c, 32'hffffffff);
      rd(5'h1c, 32'h0);
      chk(32'(led), 32'h0);
      $display("test 1 done");
      // every step of init and basic, then run
      for (i = 1; i <= 23; i++)
      begin
         env.steps(1);
         rd(ssr_pkg::OFS_STATE, 32'(i < 9 ? 1 : (i < 23 ? 2 : 0)));
         rd(ssr_pkg::OFS_SUB, 32'(i < 9 ? i : (i < 23 ? i - 9 : 0)));
      end
      chk(32'(sto), 32'h0);
      $display("test 2 done");
      // parameterization, reloading and module change, each resumed
      for (k = 1; k <= 3; k++)
      begin
         bus(1'b1, ssr_pkg::OFS_CMD, {20'h0, 4'ha, 5'h0, 3'(k)});
         rd(ssr_pkg::OFS_STATE, 32'(k + 2));
         rd(ssr_pkg::OFS_SUB, k == 1 ? 32'ha : 32'h0);
         if (k == 1)
         begin
            bus(1'b1, ssr_pkg::OFS_CMD, 32'h00000501);
            rd(ssr_pkg::OFS_SUB, 32'h5);
         end
         // resume restarts the whole start-up sequence
         bus(1'b1, ssr_pkg::OFS_CMD, 32'(ssr_pkg::CMD_RESUME));
         rd(ssr_pkg::OFS_STATE, 32'(ssr_pkg::ST_INIT));
         rd(ssr_pkg::OFS_SUB, 32'h0);
         env.steps(23);
         rd(ssr_pkg::OFS_STATE, 32'h0);
      end
      $display("test 3 done");
      // axis limits, pins need settling through the synchroniser
      lim <= 2'b01;
      repeat (4) @(posedge clk_i);
      rd(ssr_pkg::OFS_STATE, 32'(ssr_pkg::ST_SAFEFN));
      rd(ssr_pkg::OFS_SUB, 32'h1);
      lim <= 2'b11;
      repeat (4) @(posedge clk_i);
      rd(ssr_pkg::OFS_SUB, 32'h3);
      lim <= 2'b00;
      repeat (4) @(posedge clk_i);
      rd(ssr_pkg::OFS_STATE, 32'h0);
      $display("test 4 done");
      // encoder standstill and user acknowledge
      enc_on <= 1'b1;
      bus(1'b1, ssr_pkg::OFS_CTRL, 32'h1);
      repeat (60) @(posedge clk_i);
      rd(ssr_pkg::OFS_STATE, 32'h0);
      enc_on <= 1'b0;
      repeat (40) @(posedge clk_i);
      rd(ssr_pkg::OFS_STATE, 32'(ssr_pkg::ST_ENCFAIL));
      bus(1'b1, ssr_pkg::OFS_CTRL, 32'h2);
      rd(ssr_pkg::OFS_STATE, 32'h0);
      rd(ssr_pkg::OFS_CTRL, 32'h0);
      $display("test 5 done");
      // reaction delay register and a non-critical error
      bus(1'b1, ssr_pkg::OFS_DLY, 32'hffffffff);
      rd(ssr_pkg::OFS_DLY, 32'h00ffffff);
      bus(1'b1, ssr_pkg::OFS_DLY, 32'h3);
      ecode <= 8'h17;
      edet <= 16'hbeef;
      err <= 1'b1;
      @(posedge clk_i);
      err <= 1'b0;
      #1;
      chk(32'(led), 32'h1);
      chk(32'(sto), 32'h0);
      @(posedge clk_i);
      #1;
      chk(32'(sto), 32'h0);
      @(posedge clk_i);
      #1;
      chk(32'(sto), 32'h0);
      @(posedge clk_i);
      #1;
      chk(32'(sto), 32'h1);
      @(posedge clk_i);
      rd(ssr_pkg::OFS_STATE, 32'(ssr_pkg::ST_ERROR));
      rd(ssr_pkg::OFS_ERRC, 32'h17);
      rd(ssr_pkg::OFS_ERRD, 32'hbeef);
      // a later fault, step or resume must not disturb the error
      ext_f <= 3'h1;
      @(posedge clk_i);
      ext_f <= 3'h0;
      env.steps(1);
      bus(1'b1, ssr_pkg::OFS_CMD, 32'(ssr_pkg::CMD_RESUME));
      rd(ssr_pkg::OFS_STATE, 32'(ssr_pkg::ST_ERROR));
      rd(ssr_pkg::OFS_ERRC, 32'h17);
      $display("test 6 done");
      // critical error removes torque at once
      boot();
      // a delay is set so that only criticality removes torque at once
      bus(1'b1, ssr_pkg::OFS_DLY, 32'h3);
      chk(32'(sto), 32'h0);
      crit <= 1'b1;
      err <= 1'b1;
      @(posedge clk_i);
      err <= 1'b0;
      crit <= 1'b0;
      #1;
      chk(32'(sto), 32'h1);
      chk(32'(led), 32'h1);
      @(posedge clk_i);
      $display("test 7 done");
      // each outside fault in turn
      for (k = 0; k < 3; k++)
      begin
         do_reset();
         ext_f <= 3'(1 << k);
         repeat (4) @(posedge clk_i);
         ext_f <= 3'h0;
         repeat (4) @(posedge clk_i);
         rd(ssr_pkg::OFS_STATE, 32'(ssr_pkg::ST_ERROR));
         rd(ssr_pkg::OFS_ERRC, 32'(ex_codes[k]));
         rd(ssr_pkg::OFS_ERRD, 32'h0);
         chk(32'(led), 32'h1);
         chk(32'(sto), 32'h1);
      end
      $display("test 8 done");
      complete_run();
   end
endmodule // tb
